/* File: bmcf_pkg.sv */
// Notes on behaviour
// - fall-through shows a word unasked whenever the output is empty; a word behind a shown one needs a read enable.
// - fall-through pin level caught during master reset fixes the timing mode.
// - standard mode: empty and full flags; fall-through: output-ready and input-ready.
// - half-full, almost-empty and almost-full work in both timing modes.
// - almost offsets count from each boundary; reset pins pick one of eight defaults.
// - serial enable with load shifts one serial bit per write-clock edge.
// - write enable with load takes offsets from the data inputs, not the queue.
// - read enable with load puts the offsets on the data outputs.
// - master reset clears both pointers and catches all reset-time selections.
// - partial reset clears pointers but keeps mode, method and offsets.
// - after partial reset every flag is re-evaluated with settings still in force.
// - async flags: almost-empty falls on read, rises on write; almost-full reverse.
// - sync flags: almost-empty moves on read edges only, almost-full on write edges.
// - flag timing pin caught during master reset picks sync or async flags.
// - replay low at a read-clock edge returns the read pointer to the start.
// - replay latency pin at master reset: low zero latency, high normal.
// - zero latency replay loads the first word on the same read edge.
// - width pins at master reset choose 36/36, 36/18, 36/9, 18/36 or 9/36.
// - big order sends the top part of a wide word first, little the bottom.
// - byte order pin at master reset: low big order, high little order.
// - parallel offsets: interspersed skips bits 8,17,26,35; else bits 32-35 ignored.
// - parity placement touches offset loading only, never queue data.
// - a write-clock edge with write enable stores the input word.
// - a read-clock edge with read enable moves a word to the outputs.
// - fall-through: first word appears after three read-clock edges.
// - half-full shows whether the count is above half the capacity.
package bmcf_pkg;
	localparam int unsigned DW = 36;
	localparam int unsigned AW = 10;
	localparam int unsigned SYNC_W = 55;
	localparam int unsigned SEG_H = 18;
	localparam int unsigned SEG_Q = 9;
	localparam logic [AW:0] DEPTH_CNT = 11'h400;
	localparam logic [AW:0] HALF_CNT = 11'h200;
	localparam logic [1:0] LAST_X36 = 2'h0;
	localparam logic [1:0] LAST_X18 = 2'h1;
	localparam logic [1:0] LAST_X9 = 2'h3;
	// third read edge loads the first word, the first two only wait
	localparam logic [1:0] FT_WAIT = 2'h2;
	// pin levels caught during master reset
	localparam logic FT_LVL = 1'b1;
	localparam logic FLAG_SYNC_LVL = 1'b1;
	localparam logic ZERO_LAT_LVL = 1'b0;
	localparam logic BIG_LVL = 1'b0;
	localparam logic INTERSP_LVL = 1'b1;
	// default offset pairs picked by load and both select pins
	localparam logic [AW-1:0] DEF_OFF [8] = '{10'h007, 10'h00F, 10'h01F, 10'h03F,
		10'h07F, 10'h0FF, 10'h1FF, 10'h3FF};
	localparam logic [2*AW-1:0] OFF_RST = 20'h0_1C07;
endpackage

/* File: bmcf_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bmcf_sync #(
	parameter int unsigned W = bmcf_pkg::SYNC_W
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o,
	output logic [1:0] rise_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [1:0] prev_q;

	// ----------------------------------------
	// two-flop crossing, then edge finder on the two clock pins
	// ----------------------------------------
	// first stage feeds only the second; edges are found on the settled copy
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else if (ce_i) begin
			meta_q <= d_i;
			sync_q <= meta_q;
			prev_q <= sync_q[1:0];
		end
	end

	assign q_o = sync_q;
	assign rise_o = sync_q[1:0] & ~prev_q;
endmodule // bmcf_sync

`default_nettype wire

/* File: bmcf_top.sv */
`timescale 1ns/1ps
`default_nettype none

module bmcf_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wr_clk_i,
	input wire logic rd_clk_i,
	input wire logic write_en_n_i,
	input wire logic read_en_n_i,
	input wire logic offset_load_n_i,
	input wire logic serial_load_enable_n_i,
	input wire logic fallthrough_sel_serial_in_i,
	input wire logic [35:0] data_in_i,
	input wire logic full_reset_n_i,
	input wire logic pointer_reset_n_i,
	input wire logic replay_n_i,
	input wire logic replay_latency_sel_i,
	input wire logic byte_order_sel_i,
	input wire logic parity_placement_sel_i,
	input wire logic flag_timing_sel_i,
	input wire logic width_match_sel_i,
	input wire logic input_width_sel_i,
	input wire logic output_width_sel_i,
	input wire logic default_offset_sel0_i,
	input wire logic default_offset_sel1_i,
	output logic [35:0] data_out_o,
	output logic empty_flag_n_o,
	output logic full_flag_n_o,
	output logic half_full_n_o,
	output logic almost_empty_n_o,
	output logic almost_full_n_o
);
	localparam int unsigned DW = bmcf_pkg::DW;
	localparam int unsigned AW = bmcf_pkg::AW;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// slot of a beat inside the long word
	function automatic logic [1:0] seg_pos(input logic [1:0] beat, input logic [1:0] last,
		input logic big);
		seg_pos = big ? 2'(last - beat) : beat;
	endfunction

	// part of a long word moved to the low bits of a narrow port
	function automatic logic [DW-1:0] seg_get(input logic [DW-1:0] w, input logic [1:0] pos,
		input logic [1:0] last);
		logic [DW-1:0] r;
		r = w;
		if (last == bmcf_pkg::LAST_X18) begin
			r = {{(DW-bmcf_pkg::SEG_H){1'b0}}, w[pos[0]*bmcf_pkg::SEG_H +: bmcf_pkg::SEG_H]};
		end else if (last == bmcf_pkg::LAST_X9) begin
			r = {{(DW-bmcf_pkg::SEG_Q){1'b0}}, w[pos*bmcf_pkg::SEG_Q +: bmcf_pkg::SEG_Q]};
		end
		seg_get = r;
	endfunction

	// narrow input beat placed into its slot of the long word
	function automatic logic [DW-1:0] seg_put(input logic [DW-1:0] acc, input logic [DW-1:0] d,
		input logic [1:0] pos, input logic [1:0] last);
		logic [DW-1:0] r;
		r = d;
		if (last == bmcf_pkg::LAST_X18) begin
			r = acc;
			r[pos[0]*bmcf_pkg::SEG_H +: bmcf_pkg::SEG_H] = d[bmcf_pkg::SEG_H-1:0];
		end else if (last == bmcf_pkg::LAST_X9) begin
			r = acc;
			r[pos*bmcf_pkg::SEG_Q +: bmcf_pkg::SEG_Q] = d[bmcf_pkg::SEG_Q-1:0];
		end
		seg_put = r;
	endfunction

	// ----------------------------------------
	// pin crossing
	// ----------------------------------------
	logic [bmcf_pkg::SYNC_W-1:0] sync_q;
	logic [1:0] rise;
	logic s_wclk, s_rclk, s_wen_n, s_ren_n, s_load_n, s_sen_n, s_ftsi, s_mrs_n, s_prs_n;
	logic s_replay_n, s_rlat, s_order, s_par, s_pfm, s_bm, s_iw, s_ow, s_fs0, s_fs1;
	logic [DW-1:0] s_data;

	// both link clocks are plain pins here, sampled like the rest
	bmcf_sync #(
		.W(bmcf_pkg::SYNC_W)
	) u_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({data_in_i, default_offset_sel1_i, default_offset_sel0_i, output_width_sel_i,
			input_width_sel_i, width_match_sel_i, flag_timing_sel_i, parity_placement_sel_i,
			byte_order_sel_i, replay_latency_sel_i, replay_n_i, pointer_reset_n_i,
			full_reset_n_i, fallthrough_sel_serial_in_i, serial_load_enable_n_i,
			offset_load_n_i, read_en_n_i, write_en_n_i, rd_clk_i, wr_clk_i}),
		.q_o(sync_q),
		.rise_o(rise)
	);

	assign {s_data, s_fs1, s_fs0, s_ow, s_iw, s_bm, s_pfm, s_par, s_order, s_rlat, s_replay_n,
		s_prs_n, s_mrs_n, s_ftsi, s_sen_n, s_load_n, s_ren_n, s_wen_n, s_rclk, s_wclk} = sync_q;

	logic full_reset_n, pointer_reset_n, wr_go, rd_go;
	assign full_reset_n = !s_mrs_n;
	assign pointer_reset_n = !s_prs_n && s_mrs_n;
	// pin data are delayed as much as the clocks, so they are read as at the edge
	assign wr_go = ce_i && rise[0];
	assign rd_go = ce_i && rise[1];

	// ----------------------------------------
	// selections caught at master reset
	// ----------------------------------------
	logic fall_through_mode_q, flag_sync_q, zero_lat_q, big_endian_q, interspersed_q;
	logic [1:0] in_last_q, out_last_q;

	// only a master reset reloads these; partial reset leaves them alone
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fall_through_mode_q <= 1'b0;
			flag_sync_q <= 1'b0;
			zero_lat_q <= 1'b0;
			big_endian_q <= 1'b0;
			interspersed_q <= 1'b0;
			in_last_q <= bmcf_pkg::LAST_X36;
			out_last_q <= bmcf_pkg::LAST_X36;
		end else if (ce_i && full_reset_n) begin
			fall_through_mode_q <= s_ftsi == bmcf_pkg::FT_LVL;
			flag_sync_q <= s_pfm == bmcf_pkg::FLAG_SYNC_LVL;
			zero_lat_q <= s_rlat == bmcf_pkg::ZERO_LAT_LVL;
			big_endian_q <= s_order == bmcf_pkg::BIG_LVL;
			interspersed_q <= s_par == bmcf_pkg::INTERSP_LVL;
			if (!s_bm) begin
				in_last_q <= bmcf_pkg::LAST_X36;
				out_last_q <= bmcf_pkg::LAST_X36;
			end else if (!s_iw) begin
				in_last_q <= bmcf_pkg::LAST_X36;
				out_last_q <= s_ow ? bmcf_pkg::LAST_X9 : bmcf_pkg::LAST_X18;
			end else begin
				in_last_q <= s_ow ? bmcf_pkg::LAST_X9 : bmcf_pkg::LAST_X18;
				out_last_q <= bmcf_pkg::LAST_X36;
			end
		end
	end

	// ----------------------------------------
	// queue state
	// ----------------------------------------
	logic [DW-1:0] mem_q [2**AW];
	logic [AW:0] wptr_q, rptr_q, mem_cnt;
	logic [1:0] wbeat_q, rbeat_q;
	logic [DW-1:0] acc_q, mem_wd, data_out_q;
	logic word_av, is_full, wr_take, mem_we;

	assign mem_cnt = wptr_q - rptr_q;
	assign word_av = mem_cnt != '0;
	assign is_full = mem_cnt >= bmcf_pkg::DEPTH_CNT;

	// a queue beat is taken only with load high and room left
	assign wr_take = wr_go && !s_wen_n && s_load_n && !is_full && s_mrs_n && s_prs_n;
	assign mem_we = wr_take && (wbeat_q == in_last_q);
	assign mem_wd = seg_put(acc_q, s_data, seg_pos(wbeat_q, in_last_q, big_endian_q), in_last_q);

	// ----------------------------------------
	// write side
	// ----------------------------------------
	// narrow beats gather in acc_q; the last beat writes the whole word
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_q <= '0;
			wbeat_q <= '0;
			acc_q <= '0;
		end else if (ce_i) begin
			if (full_reset_n || pointer_reset_n) begin
				wptr_q <= '0;
				wbeat_q <= '0;
			end else if (wr_take) begin
				acc_q <= mem_wd;
				if (mem_we) begin
					wptr_q <= wptr_q + 1'b1;
					wbeat_q <= '0;
				end else begin
					wbeat_q <= wbeat_q + 1'b1;
				end
			end
		end
	end

	// storage has no reset; stale words are never readable past the pointers
	always_ff @(posedge clock_i) begin
		if (ce_i && mem_we) begin
			mem_q[wptr_q[AW-1:0]] <= mem_wd;
		end
	end

	// ----------------------------------------
	// offset registers
	// ----------------------------------------
	logic [2*AW-1:0] off_q;
	logic [AW-1:0] ae_off, af_off, par_off;
	logic load_sel_q;

	assign ae_off = off_q[AW-1:0];
	assign af_off = off_q[2*AW-1:AW];
	// interspersed mode skips bit 8; bits 32 to 35 never reach a 10-bit offset
	assign par_off = interspersed_q ? {s_data[10:9], s_data[7:0]} : s_data[AW-1:0];

	// parallel loads alternate empty offset then full offset
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			off_q <= bmcf_pkg::OFF_RST;
			load_sel_q <= 1'b0;
		end else if (ce_i) begin
			if (full_reset_n) begin
				off_q <= {2{bmcf_pkg::DEF_OFF[{s_load_n, s_fs1, s_fs0}]}};
				load_sel_q <= 1'b0;
			end else if (wr_go && !s_load_n && s_prs_n) begin
				if (!s_wen_n) begin
					if (load_sel_q) begin
						off_q[2*AW-1:AW] <= par_off;
					end else begin
						off_q[AW-1:0] <= par_off;
					end
					load_sel_q <= !load_sel_q;
				end else if (!s_sen_n) begin
					off_q <= {s_ftsi, off_q[2*AW-1:1]};
				end
			end
		end
	end

	// ----------------------------------------
	// read side
	// ----------------------------------------
	logic out_valid_q, rb_sel_q, rd_take, rd_replay, zl_load;
	logic [1:0] ft_cnt_q, beat_base;
	logic [AW:0] rd_base;
	logic [DW-1:0] rd_word;

	assign rd_replay = !s_replay_n;
	assign rd_base = rd_replay ? '0 : rptr_q;
	assign beat_base = rd_replay ? '0 : rbeat_q;
	assign rd_word = seg_get(mem_q[rd_base[AW-1:0]],
		seg_pos(beat_base, out_last_q, big_endian_q), out_last_q);
	assign zl_load = zero_lat_q && (wptr_q != '0);
	// fall-through loads unasked only into an empty output register
	assign rd_take = word_av && s_load_n && (fall_through_mode_q ?
		(out_valid_q ? !s_ren_n : (ft_cnt_q == bmcf_pkg::FT_WAIT)) : !s_ren_n);

	// replay outranks readback, readback outranks queue reads
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rptr_q <= '0;
			rbeat_q <= '0;
			data_out_q <= '0;
			out_valid_q <= 1'b0;
			rb_sel_q <= 1'b0;
			ft_cnt_q <= '0;
		end else if (ce_i) begin
			if (full_reset_n || pointer_reset_n) begin
				rptr_q <= '0;
				rbeat_q <= '0;
				data_out_q <= '0;
				out_valid_q <= 1'b0;
				ft_cnt_q <= '0;
				if (full_reset_n) begin
					rb_sel_q <= 1'b0;
				end
			end else if (rd_go) begin
				if ((rd_replay && zl_load) || (!rd_replay && rd_take)) begin
					data_out_q <= rd_word;
					out_valid_q <= 1'b1;
					ft_cnt_q <= '0;
					if (beat_base == out_last_q) begin
						rptr_q <= rd_base + 1'b1;
						rbeat_q <= '0;
					end else begin
						rptr_q <= rd_base;
						rbeat_q <= beat_base + 1'b1;
					end
				end else if (rd_replay) begin
					rptr_q <= '0;
					rbeat_q <= '0;
					out_valid_q <= 1'b0;
					ft_cnt_q <= '0;
				end else if (!s_ren_n && !s_load_n) begin
					data_out_q <= {{(DW-AW){1'b0}}, rb_sel_q ? af_off : ae_off};
					rb_sel_q <= !rb_sel_q;
				end else begin
					// reader took the last shown word and nothing follows
					if (!s_ren_n && s_load_n && fall_through_mode_q) begin
						out_valid_q <= 1'b0;
					end
					if (fall_through_mode_q && !out_valid_q && word_av) begin
						ft_cnt_q <= ft_cnt_q + 1'b1;
					end else begin
						ft_cnt_q <= '0;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	logic empty_q, full_q, half_q, ae_q, af_q, ae_cond, af_cond;
	logic [AW:0] free_cnt;
	logic wr_seen_q, rd_seen_q;

	// the count settles one cycle after a take, so the almost flags look a cycle late
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_seen_q <= 1'b0;
			rd_seen_q <= 1'b0;
		end else if (ce_i) begin
			wr_seen_q <= wr_go;
			rd_seen_q <= rd_go;
		end
	end

	assign free_cnt = bmcf_pkg::DEPTH_CNT - mem_cnt;
	assign ae_cond = mem_cnt <= {1'b0, ae_off};
	assign af_cond = free_cnt <= {1'b0, af_off};

	// the empty and full pins change meaning with the timing mode; the rest never do
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			empty_q <= 1'b0;
			full_q <= 1'b1;
			half_q <= 1'b1;
			ae_q <= 1'b0;
			af_q <= 1'b1;
		end else if (ce_i) begin
			if (full_reset_n || pointer_reset_n) begin
				empty_q <= fall_through_mode_q;
				full_q <= !fall_through_mode_q;
				half_q <= 1'b1;
				ae_q <= 1'b0;
				af_q <= 1'b1;
			end else begin
				empty_q <= fall_through_mode_q ? !out_valid_q : word_av;
				full_q <= fall_through_mode_q ? is_full : !is_full;
				half_q <= !(mem_cnt > bmcf_pkg::HALF_CNT);
				if (flag_sync_q) begin
					if (rd_seen_q) begin
						ae_q <= !ae_cond;
					end
					if (wr_seen_q) begin
						af_q <= !af_cond;
					end
				end else begin
					if (rd_seen_q && ae_cond) begin
						ae_q <= 1'b0;
					end else if (wr_seen_q && !ae_cond) begin
						ae_q <= 1'b1;
					end
					if (wr_seen_q && af_cond) begin
						af_q <= 1'b0;
					end else if (rd_seen_q && !af_cond) begin
						af_q <= 1'b1;
					end
				end
			end
		end
	end

	assign data_out_o = data_out_q;
	assign empty_flag_n_o = empty_q;
	assign full_flag_n_o = full_q;
	assign half_full_n_o = half_q;
	assign almost_empty_n_o = ae_q;
	assign almost_full_n_o = af_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_wr_try;
		ce_i && wr_go && !s_wen_n && s_load_n && s_mrs_n && s_prs_n;
	endsequence
	sequence s_rd_try;
		ce_i && rd_go && !s_ren_n && s_load_n && s_replay_n && s_mrs_n && s_prs_n;
	endsequence
	sequence s_replay;
		ce_i && rd_go && rd_replay && s_mrs_n && s_prs_n;
	endsequence

	a_mode_hold: assert property (ce_i && !full_reset_n |=> $stable(fall_through_mode_q))
		else $error("timing mode moved outside master reset");
	a_wr_store: assert property (s_wr_try ##0 (!is_full && wbeat_q == in_last_q)
		|=> wptr_q == $past(wptr_q) + 1'b1)
		else $error("accepted write did not advance the write pointer");
	a_wr_refuse: assert property (s_wr_try ##0 is_full |=> $stable(wptr_q))
		else $error("write accepted while full");
	a_rd_refuse: assert property (s_rd_try ##0 !word_av |=> $stable(rptr_q))
		else $error("read pointer moved while empty");
	a_replay_ptr: assert property (s_replay |=> rptr_q <= 11'h001 && rbeat_q <= 2'h1)
		else $error("replay did not return the read pointer");
	a_zero_lat: assert property (s_replay ##0 zl_load
		|=> out_valid_q && data_out_q == $past(rd_word))
		else $error("zero latency replay did not load the first word");
	a_serial_shift: assert property (ce_i && wr_go && !s_load_n && s_wen_n && !s_sen_n
		&& s_mrs_n && s_prs_n |=> off_q == {$past(s_ftsi), $past(off_q[2*AW-1:1])})
		else $error("serial offset bit not shifted in");
	a_offset_read: assert property (ce_i && rd_go && !s_ren_n && !s_load_n && s_replay_n
		&& s_mrs_n && s_prs_n |=> data_out_q[AW-1:0] == ($past(rb_sel_q) ? af_off : ae_off))
		else $error("offset readback wrong");
	a_prs_keep: assert property (ce_i && pointer_reset_n |=> $stable(off_q)
		&& $stable(fall_through_mode_q) && wptr_q == '0 && rptr_q == '0)
		else $error("partial reset disturbed settings or pointers");
	a_ae_sync: assert property (ce_i && flag_sync_q && !rd_seen_q && s_mrs_n && s_prs_n
		|=> $stable(ae_q))
		else $error("sync almost-empty moved without a read edge");
endmodule // bmcf_top

`default_nettype wire

/* File: bmcf_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// writer and reader logic facing the queue ports
// ------------------------------------------------------------
module bmcf_far_end (
	input wire logic clock_i,
	output logic wr_clk_o,
	output logic rd_clk_o,
	output logic write_en_n_o,
	output logic read_en_n_o,
	output logic offset_load_n_o,
	output logic serial_load_enable_n_o,
	output logic fallthrough_sel_serial_in_o,
	output logic [35:0] data_in_o,
	output logic replay_n_o
);
	// idle levels, then a free running write clock with its own phase
	initial begin
		write_en_n_o = 1'b1;
		read_en_n_o = 1'b1;
		offset_load_n_o = 1'b1;
		serial_load_enable_n_o = 1'b1;
		fallthrough_sel_serial_in_o = 1'b0;
		data_in_o = 36'h5_A5A5_A5A5;
		replay_n_o = 1'b1;
		wr_clk_o = 1'b0;
		#1.7;
		forever #24 wr_clk_o = ~wr_clk_o;
	end
	// read clock, phase unrelated to both other clocks
	initial begin
		rd_clk_o = 1'b0;
		#13.1;
		forever #24 rd_clk_o = ~rd_clk_o;
	end
	// levels caught while master reset is low
	task automatic preset(input logic ft, input logic ld_n);
		@(posedge clock_i);
		fallthrough_sel_serial_in_o <= ft;
		offset_load_n_o <= ld_n;
	endtask
	// one write-clock operation; held well past the synchronised edge
	task automatic wbeat(input logic we_n, input logic ld_n, input logic sen_n, input logic si,
		input logic [35:0] d);
		@(negedge wr_clk_o);
		@(posedge clock_i);
		write_en_n_o <= we_n;
		offset_load_n_o <= ld_n;
		serial_load_enable_n_o <= sen_n;
		fallthrough_sel_serial_in_o <= si;
		data_in_o <= d;
		@(posedge wr_clk_o);
		repeat (5) @(posedge clock_i);
		write_en_n_o <= 1'b1;
		offset_load_n_o <= 1'b1;
		serial_load_enable_n_o <= 1'b1;
		fallthrough_sel_serial_in_o <= ~si;
		data_in_o <= ~d; // released bus must not keep a stale word
	endtask
	// one read-clock operation, same holding discipline
	task automatic rbeat(input logic re_n, input logic ld_n, input logic rt_n);
		@(negedge rd_clk_o);
		@(posedge clock_i);
		read_en_n_o <= re_n;
		offset_load_n_o <= ld_n;
		replay_n_o <= rt_n;
		@(posedge rd_clk_o);
		repeat (5) @(posedge clock_i);
		read_en_n_o <= 1'b1;
		offset_load_n_o <= 1'b1;
		replay_n_o <= 1'b1;
	endtask
endmodule // bmcf_far_end

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module tb_top;
	logic clock_i, rst_i, full_reset_n_i, pointer_reset_n_i;
	logic rm, be, ip, flag_timing_sel, bm, iw, ow, s0, s1;
	wire logic wr_clk, rd_clk, we_n, re_n, ld_n, sen_n, ftsi, rt_n;
	wire logic ef_n, ff_n, hf_n, ae_n, af_n;
	wire logic [35:0] din, dout;
	int seed, check_count, n_fail, i, k, m, n;
	logic [35:0] q [8];
	logic [35:0] w;
	logic [19:0] sp;
	logic [2:0] wtab [4] = '{3'b100, 3'b101, 3'b110, 3'b111};

	// ------------------------------------------------------------
	// parts under test
	// ------------------------------------------------------------
	// clock enable tied on: freezing is not a documented behaviour
	bmcf_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .wr_clk_i(wr_clk),
		.rd_clk_i(rd_clk), .write_en_n_i(we_n), .read_en_n_i(re_n), .offset_load_n_i(ld_n),
		.serial_load_enable_n_i(sen_n), .fallthrough_sel_serial_in_i(ftsi), .data_in_i(din),
		.full_reset_n_i(full_reset_n_i), .pointer_reset_n_i(pointer_reset_n_i),
		.replay_n_i(rt_n), .replay_latency_sel_i(rm), .byte_order_sel_i(be),
		.parity_placement_sel_i(ip), .flag_timing_sel_i(flag_timing_sel), .width_match_sel_i(bm),
		.input_width_sel_i(iw), .output_width_sel_i(ow), .default_offset_sel0_i(s0),
		.default_offset_sel1_i(s1), .data_out_o(dout), .empty_flag_n_o(ef_n),
		.full_flag_n_o(ff_n), .half_full_n_o(hf_n), .almost_empty_n_o(ae_n),
		.almost_full_n_o(af_n));
	bmcf_far_end u_far (.clock_i(clock_i), .wr_clk_o(wr_clk), .rd_clk_o(rd_clk),
		.write_en_n_o(we_n), .read_en_n_o(re_n), .offset_load_n_o(ld_n),
		.serial_load_enable_n_o(sen_n), .fallthrough_sel_serial_in_o(ftsi), .data_in_o(din),
		.replay_n_o(rt_n));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [35:0] rnd36();
		logic [63:0] r;
		r = {$random(seed), $random(seed)};
		return r[35:0];
	endfunction
	// offset a parallel load should keep; parity bits skipped when interspersed
	function automatic logic [9:0] exp_off(input logic [35:0] d, input logic isp);
		return isp ? {d[10:9], d[7:0]} : d[9:0];
	endfunction
	// k-th of n narrow parts of a wide word, order chosen by big
	function automatic logic [35:0] piece(input logic [35:0] x, input int kk, input int nn,
		input logic big);
		int wd;
		int lo;
		wd = 36 / nn;
		lo = big ? 36 - (kk + 1) * wd : kk * wd;
		return (x >> lo) & ((36'h1 << wd) - 36'h1);
	endfunction
	task automatic wr(input logic [35:0] d);
		u_far.wbeat(1'b0, 1'b1, 1'b1, 1'b0, d);
	endtask
	task automatic rd();
		u_far.rbeat(1'b0, 1'b1, 1'b1);
	endtask
	// both offsets read back, empty first
	task automatic chk_off(input logic [9:0] e, input logic [9:0] f);
		u_far.rbeat(1'b0, 1'b0, 1'b1);
		`CHK("empty offset", e, dout[9:0])
		u_far.rbeat(1'b0, 1'b0, 1'b1);
		`CHK("full offset", f, dout[9:0])
	endtask
	// config pins held over the whole low phase, caught at release
	task automatic mr(input logic ft, input logic ld);
		u_far.preset(ft, ld);
		full_reset_n_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		full_reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		u_far.preset(1'b0, 1'b1);
	endtask
	task automatic chk_idle();
		`CHK("empty flag", 1'b0, ef_n)
		`CHK("full flag", 1'b1, ff_n)
		`CHK("half flag", 1'b1, hf_n)
		`CHK("almost empty", 1'b0, ae_n)
		`CHK("almost full", 1'b1, af_n)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	// whole run is about 60 us; a hang is cut well past that
	initial begin
		#300_000;
		n_fail++;
		summarize();
	end
	initial begin
		seed = 32'h6711_7d6a;
		{check_count, n_fail} = '0;
		{rst_i, full_reset_n_i, pointer_reset_n_i} = 3'b111;
		{rm, be, ip, flag_timing_sel, bm, iw, ow, s0, s1} = '0;
		rm = ~bmcf_pkg::ZERO_LAT_LVL;
		ip = bmcf_pkg::INTERSP_LVL;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		// defaults, threshold edges, plain traffic, read when empty
		mr(~bmcf_pkg::FT_LVL, 1'b0);
		chk_idle();
		chk_off(bmcf_pkg::DEF_OFF[0], bmcf_pkg::DEF_OFF[0]);
		for (i = 0; i < 8; i++) begin
			q[i] = rnd36();
			wr(q[i]);
			`CHK("almost empty", logic'(i + 1 > 7), ae_n)
		end
		for (i = 0; i < 8; i++) begin
			rd();
			`CHK("read word", q[i], dout)
			`CHK("almost empty", 1'b0, ae_n)
		end
		rd();
		`CHK("held word", q[7], dout)
		u_far.rbeat(1'b1, 1'b1, 1'b0);
		`CHK("normal replay", q[7], dout)
		rd();
		`CHK("replayed word", q[0], dout)
		// parallel offsets in both parity placements
		for (k = 0; k < 2; k++) begin
			ip <= k[0] ? bmcf_pkg::INTERSP_LVL : ~bmcf_pkg::INTERSP_LVL;
			mr(~bmcf_pkg::FT_LVL, 1'b1);
			q[0] = rnd36();
			q[1] = rnd36();
			u_far.wbeat(1'b0, 1'b0, 1'b1, 1'b0, q[0]);
			u_far.wbeat(1'b0, 1'b0, 1'b1, 1'b0, q[1]);
			`CHK("no queue word", 1'b0, ef_n)
			chk_off(exp_off(q[0], ip), exp_off(q[1], ip));
		end
		// serial offsets, then fill past full and partial reset
		sp = 20'(rnd36());
		for (i = 0; i < 20; i++)
			u_far.wbeat(1'b1, 1'b0, 1'b0, sp[i], rnd36());
		chk_off(sp[9:0], sp[19:10]);
		for (i = 0; i < 1025; i++) begin
			wr(rnd36());
			`CHK("half flag", logic'(i + 1 <= 512), hf_n)
			`CHK("full flag", logic'(i < 1023), ff_n)
			`CHK("almost full", logic'(1023 - i > int'(sp[19:10])), af_n)
			`CHK("almost empty", logic'(i + 1 > sp[9:0]), ae_n)
		end
		pointer_reset_n_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		pointer_reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk_idle();
		chk_off(sp[9:0], sp[19:10]);
		// zero latency replay
		rm <= bmcf_pkg::ZERO_LAT_LVL;
		mr(~bmcf_pkg::FT_LVL, 1'b1);
		for (i = 0; i < 3; i++) begin
			q[i] = rnd36();
			wr(q[i]);
		end
		rd();
		rd();
		u_far.rbeat(1'b1, 1'b1, 1'b0);
		`CHK("replay word", q[0], dout)
		rd();
		`CHK("after replay", q[1], dout)
		// width matching, both byte orders
		for (m = 0; m < 8; m++) begin
			{bm, iw, ow} <= wtab[m / 2];
			be <= m[0];
			n = wtab[m / 2][0] ? 4 : 2;
			mr(~bmcf_pkg::FT_LVL, 1'b1);
			w = rnd36();
			if (!iw) begin
				wr(w);
				for (k = 0; k < n; k++) begin
					rd();
					`CHK("narrow out", piece(w, k, n, be == bmcf_pkg::BIG_LVL), dout)
				end
			end else begin
				for (k = 0; k < n; k++)
					wr(piece(w, k, n, be == bmcf_pkg::BIG_LVL) | (rnd36() << (36 / n)));
				rd();
				`CHK("wide out", w, dout)
			end
		end
		// fall-through with synchronous almost flags
		{bm, iw, ow, be} <= '0;
		flag_timing_sel <= bmcf_pkg::FLAG_SYNC_LVL;
		mr(bmcf_pkg::FT_LVL, 1'b1);
		`CHK("no word ready", 1'b1, ef_n)
		`CHK("space ready", 1'b0, ff_n)
		q[0] = rnd36();
		q[1] = rnd36();
		wr(q[0]);
		repeat (4) @(posedge rd_clk);
		repeat (6) @(posedge clock_i);
		`CHK("first word falls", q[0], dout)
		`CHK("word ready", 1'b0, ef_n)
		wr(q[1]);
		repeat (4) @(posedge rd_clk);
		repeat (6) @(posedge clock_i);
		`CHK("second waits", q[0], dout)
		`CHK("almost empty", 1'b0, ae_n)
		rd();
		`CHK("second read", q[1], dout)
		rd();
		`CHK("drained", 1'b1, ef_n)
		summarize();
	end
endmodule // tb_top

`default_nettype wire
